// file: pkg/icds_pkg.sv
package icds_pkg;
  localparam logic [6:0] ICDS_DEV_ADDR = 7'h48;
  localparam logic [7:0] ICDS_MEM_FIRST = 8'hF8;
  localparam logic [7:0] ICDS_MEM_SECOND = 8'hF9;
  localparam logic [7:0] ICDS_SETTING_RST = 8'h00;
  localparam int ICDS_SIGN_BIT = 7;
  localparam int ICDS_MAG_MSB = 6;
  localparam int ICDS_BYTE_BITS = 8;
  localparam int ICDS_SYNC_STAGES = 2;

  typedef struct packed {
    logic sign;
    logic [6:0] magnitude_field;
  } icds_setting_t;

  typedef struct packed {
    logic sourcing;
    logic sinking;
    logic [6:0] magnitude_field;
  } icds_drive_t;

  typedef enum logic [2:0] {
    ICDS_IDLE = 3'b000,
    ICDS_ADDR = 3'b001,
    ICDS_WACK = 3'b011,
    ICDS_WDATA = 3'b010,
    ICDS_RDATA = 3'b111,
    ICDS_RACK = 3'b110,
    ICDS_IGNORE = 3'b101
  } icds_state_t;
endpackage

// file: core/icds_slave.sv
// Functional notes
// RULE1 - Read bits change after SCL falling edge, stable at next rising edge.
// RULE2 - Master releases SDA before rising edge of a read bit.
// RULE3 - Master generates every SCL pulse, including read pulses.
// RULE4 - Ninth bit is acknowledge; receiver drives it low.
// RULE5 - High ninth bit is not-acknowledge: ends a read or refuses data.
// RULE6 - Write bytes are eight bits MSB first, then device acknowledge.
// RULE7 - Read bytes MSB first; master NACK ends, device then releases SDA.
// RULE8 - First byte after start is address: seven address bits plus direction.
// RULE9 - Address byte 90h is a write to the device.
// RULE10 - Address byte 91h is a read from the device.
// RULE11 - Mismatched address: stay passive until next start.
// RULE12 - Second write byte is the memory address.
// RULE13 - Write: start, address, memory address, data, stop; each acknowledged.
// RULE14 - Read: start, address, one data byte with NACK, stop.
// RULE15 - Write bits sampled on SCL rising edge.
// RULE16 - Memory F8h selects first output setting, F9h the second.
// RULE17 - Setting top bit: zero sinks, one sources.
// RULE18 - Low seven bits are magnitude; zero magnitude gives no output.
// RULE19 - Read returns setting selected by last written memory address.
// RULE20 - Data to other memory addresses is acknowledged and discarded.
`timescale 1ns/1ns
module icds_slave (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output icds_pkg::icds_setting_t first_setting_o,
  output icds_pkg::icds_setting_t second_setting_o,
  output icds_pkg::icds_drive_t first_current_output_o,
  output icds_pkg::icds_drive_t second_current_output_o
);
  import icds_pkg::*;

  function automatic icds_drive_t to_drive(input icds_setting_t s);
    icds_drive_t d;
    d.magnitude_field = s.magnitude_field;
    d.sourcing = s.sign && (s.magnitude_field != 7'h00); // see RULE17 see RULE18
    d.sinking = !s.sign && (s.magnitude_field != 7'h00); // see RULE17 see RULE18
    return d;
  endfunction

  logic [ICDS_SYNC_STAGES-1:0] scl_sync_q;
  logic [ICDS_SYNC_STAGES-1:0] sda_sync_q;
  logic scl_q;
  logic sda_q;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      scl_sync_q <= '1;
      sda_sync_q <= '1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_q <= scl_sync_q[1];
      sda_q <= sda_sync_q[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];
  assign scl_rise = scl_s && !scl_q; // see RULE15
  assign scl_fall = !scl_s && scl_q;
  assign start_det = scl_s && scl_q && sda_q && !sda_s;
  assign stop_det = scl_s && scl_q && !sda_q && sda_s;

  icds_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [1:0] wbyte_q;
  logic [7:0] mem_addr_q;
  logic read_dir_q;
  logic byte_done;
  logic [7:0] rx_byte;
  icds_setting_t first_q;
  icds_setting_t second_q;
  icds_setting_t sel_setting;

  assign byte_done = scl_rise && (bit_cnt_q == 4'(ICDS_BYTE_BITS - 1));
  assign rx_byte = {shift_q[6:0], sda_s}; // see RULE6
  assign sel_setting = (mem_addr_q == ICDS_MEM_SECOND) ? second_q : first_q; // see RULE19

  // Bit counter counts rising edges within a byte
  always_ff @(posedge core_clk_i) begin
    if (reset_i || start_det) begin
      bit_cnt_q <= 4'h0;
    end else if (scl_rise) begin
      if (state_q == ICDS_WACK || state_q == ICDS_RACK) begin
        bit_cnt_q <= 4'h0;
      end else begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_q <= ICDS_IDLE;
      read_dir_q <= 1'b0;
      wbyte_q <= 2'd0;
    end else if (start_det) begin
      state_q <= ICDS_ADDR; // see RULE8
      wbyte_q <= 2'd0;
    end else if (stop_det) begin
      state_q <= ICDS_IDLE;
    end else begin
      unique case (state_q)
        ICDS_IDLE, ICDS_IGNORE: begin
          state_q <= state_q; // see RULE11
        end
        ICDS_ADDR: begin
          if (byte_done) begin
            if (rx_byte[7:1] == ICDS_DEV_ADDR) begin // see RULE9 see RULE10
              state_q <= ICDS_WACK;
              read_dir_q <= rx_byte[0];
            end else begin
              state_q <= ICDS_IGNORE; // see RULE11
            end
          end
        end
        ICDS_WACK: begin
          if (scl_fall && bit_cnt_q == 4'h0) begin
            state_q <= read_dir_q ? ICDS_RDATA : ICDS_WDATA;
          end
        end
        ICDS_WDATA: begin
          if (byte_done) begin
            state_q <= ICDS_WACK; // see RULE13
            if (wbyte_q != 2'd3) begin
              wbyte_q <= wbyte_q + 2'd1;
            end
          end
        end
        ICDS_RDATA: begin
          if (byte_done) begin
            state_q <= ICDS_RACK;
          end
        end
        ICDS_RACK: begin
          if (scl_rise) begin
            state_q <= sda_s ? ICDS_IGNORE : ICDS_RDATA; // see RULE5 see RULE7 see RULE14
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      shift_q <= 8'h00;
    end else if (state_q == ICDS_RDATA || state_q == ICDS_RACK) begin
      if (scl_fall && state_q == ICDS_RDATA && bit_cnt_q != 4'h0) begin
        shift_q <= {shift_q[6:0], 1'b1}; // see RULE1
      end else if (scl_fall && bit_cnt_q == 4'h0) begin
        shift_q <= sel_setting;
      end
    end else if (state_q == ICDS_WACK && read_dir_q) begin
      shift_q <= sel_setting;
    end else if (scl_rise) begin
      shift_q <= rx_byte; // see RULE15
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mem_addr_q <= 8'h00;
      first_q <= ICDS_SETTING_RST;
      second_q <= ICDS_SETTING_RST;
    end else if (state_q == ICDS_WDATA && byte_done) begin
      if (wbyte_q == 2'd0) begin
        mem_addr_q <= rx_byte; // see RULE12
      end else if (wbyte_q == 2'd1) begin
        if (mem_addr_q == ICDS_MEM_FIRST) begin // see RULE16
          first_q <= rx_byte;
        end else if (mem_addr_q == ICDS_MEM_SECOND) begin
          second_q <= rx_byte;
        end // see RULE20
      end
    end
  end

  // SDA drive: ack low in ninth bit on writes, data bits on reads
  always_ff @(posedge core_clk_i) begin
    if (reset_i || start_det || stop_det) begin
      sda_o <= 1'b1;
      sda_oe_o <= 1'b0;
    end else if (scl_fall) begin
      // Eighth rise already moved the state to WACK, so the ack slot is WACK with count eight
      if (state_q == ICDS_WACK && bit_cnt_q == 4'(ICDS_BYTE_BITS)) begin
        sda_o <= 1'b0; // see RULE4
        sda_oe_o <= 1'b1;
      end else if (bit_cnt_q == 4'h0
                   && ((state_q == ICDS_WACK && read_dir_q) || state_q == ICDS_RDATA)) begin
        sda_o <= sel_setting[ICDS_SIGN_BIT]; // see RULE1 see RULE7
        sda_oe_o <= !sel_setting[ICDS_SIGN_BIT];
      end else if (state_q == ICDS_RDATA) begin
        sda_o <= shift_q[ICDS_MAG_MSB]; // see RULE1
        sda_oe_o <= !shift_q[ICDS_MAG_MSB];
      end else begin
        sda_o <= 1'b1; // see RULE7
        sda_oe_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      first_setting_o <= ICDS_SETTING_RST;
      second_setting_o <= ICDS_SETTING_RST;
      first_current_output_o <= '0;
      second_current_output_o <= '0;
    end else begin
      first_setting_o <= first_q;
      second_setting_o <= second_q;
      first_current_output_o <= to_drive(first_q);
      second_current_output_o <= to_drive(second_q);
    end
  end
endmodule // icds_slave

// file: verif/icds_monitor.sv
`timescale 1ns/1ns
module icds_monitor (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire icds_pkg::icds_setting_t first_setting_o,
  input wire icds_pkg::icds_setting_t second_setting_o,
  input wire icds_pkg::icds_drive_t first_current_output_o,
  input wire icds_pkg::icds_drive_t second_current_output_o
);
  import icds_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_f; $stable(first_setting_o) [*3]; endsequence
  sequence s_s; $stable(second_setting_o) [*3]; endsequence
  property p_od; sda_oe_o |-> !sda_o; endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  property p_bus; sda_oe_o |-> !sda_i; endproperty
  a_bus: assert property (p_bus) else $error("driven low but bus reads high");
  property p_rise; $rose(sda_oe_o) |-> !scl_i; endproperty
  a_rise: assert property (p_rise) else $error("drive began with scl high");
  property p_hold; $rose(scl_i) |=> $stable(sda_oe_o) [*4]; endproperty
  a_hold: assert property (p_hold) else $error("drive moved with scl high");
  property p_rel; $rose(sda_oe_o) |-> ##[1:200] !sda_oe_o; endproperty
  a_rel: assert property (p_rel) else $error("sda never released");
  property p_wr; $changed(first_setting_o) |-> scl_i && !sda_oe_o; endproperty
  a_wr: assert property (p_wr) else $error("setting moved off a rising bit");
  property p_z; first_current_output_o[6:0] == 0 |-> first_current_output_o[8:7] == 0; endproperty
  a_z: assert property (p_z) else $error("zero magnitude drives current");
  property p_fs; s_f ##0 (|first_setting_o[6:0]) |->
    first_current_output_o[8:7] == {first_setting_o[7], !first_setting_o[7]}; endproperty
  a_fs: assert property (p_fs) else $error("first direction wrong");
  property p_ss; s_s ##0 (|second_setting_o[6:0]) |->
    second_current_output_o[8:7] == {second_setting_o[7], !second_setting_o[7]}; endproperty
  a_ss: assert property (p_ss) else $error("second direction wrong");
endmodule // icds_monitor

// file: verif/icds_master.sv
`timescale 1ns/1ns
module icds_master (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  localparam int Q = 16;
  initial begin
    scl_o = 1;
    sda_low_o = 0;
  end
  task xfer(input logic v, output logic r);
    sda_low_o = !v;
    #Q scl_o = 1;
    #Q r = sda_i;
    #Q scl_o = 0;
    #Q;
  endtask
  task start();
    sda_low_o = 1;
    #Q scl_o = 0;
    #Q;
  endtask
  task stop();
    sda_low_o = 1;
    #Q scl_o = 1;
    #Q sda_low_o = 0;
    #Q;
  endtask
  task wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(b[i], r);
    xfer(1'b1, ack);
  endtask
  task rd_byte(output logic [7:0] b, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(1'b1, b[i]);
    xfer(nack, r);
  endtask
endmodule // icds_master

// file: verif/icds_slave_bench.sv
`timescale 1ns/1ns
module icds_slave_bench;
  import icds_pkg::*;
  logic clk = 0, reset_i = 1, sda, sda_o, oe, scl, low;
  logic [2:0] k;
  logic [7:0] rb;
  icds_setting_t s0, s1;
  icds_drive_t c0, c1;
  int miscompares = 0, tests_run = 0;
  always #2 clk = ~clk;
  assign sda = !(low || (oe && !sda_o));
  icds_master icds_master_inst (.scl_o(scl), .sda_low_o(low), .sda_i(sda));
  icds_slave icds_slave_inst (.core_clk_i(clk), .reset_i(reset_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(oe), .first_setting_o(s0), .second_setting_o(s1),
    .first_current_output_o(c0), .second_current_output_o(c1));
  task end_of_test();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [8:0] g, e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, m, d);
    @(posedge clk);
    #1;
    icds_master_inst.start();
    icds_master_inst.wr_byte(a, k[2]);
    icds_master_inst.wr_byte(m, k[1]);
    icds_master_inst.wr_byte(d, k[0]);
    icds_master_inst.stop();
  endtask
  task t_write();
    wr(8'h90, 8'hF8, 8'hAA);
    chk({6'h0, k}, 9'h000);
    chk({1'b0, s0}, 9'h0AA);
    chk(c0, 9'h12A);
    wr(8'h90, 8'hF9, 8'h05);
    chk({1'b0, s1}, 9'h005);
    chk(c1, 9'h085);
    $display("write test done");
  endtask
  task t_read();
    @(posedge clk);
    #1;
    icds_master_inst.start();
    icds_master_inst.wr_byte(8'h91, k[0]);
    icds_master_inst.rd_byte(rb, 1'b1);
    icds_master_inst.stop();
    chk({8'h0, k[0]}, 9'h000);
    chk({1'b0, rb}, 9'h005);
    @(posedge clk);
    #1;
    icds_master_inst.start();
    icds_master_inst.wr_byte(8'h91, k[0]);
    icds_master_inst.rd_byte(rb, 1'b0);
    chk({1'b0, rb}, 9'h005);
    icds_master_inst.rd_byte(rb, 1'b1);
    icds_master_inst.stop();
    chk({8'h0, k[0]}, 9'h000);
    chk({1'b0, rb}, 9'h005);
    $display("read test done");
  endtask
  task t_misc();
    wr(8'h90, 8'hF8, 8'h80);
    chk(c0, 9'h000);
    wr(8'h90, 8'h10, 8'h33);
    chk({6'h0, k}, 9'h000);
    chk({s0, s1[0]}, 9'h101);
    wr(8'h92, 8'hF9, 8'h11);
    chk({6'h0, k}, 9'h007);
    chk({1'b0, s1}, 9'h005);
    $display("misc test done");
  endtask
  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 reset_i = 0;
    repeat (4) @(posedge clk);
    chk({s0, c0[0]}, 9'h000);
    chk({7'h0, oe, sda_o}, 9'h001);
    t_write();
    t_read();
    t_misc();
    end_of_test();
  end
endmodule // icds_slave_bench
bind icds_slave icds_monitor icds_monitor_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .first_setting_o(first_setting_o), .second_setting_o(second_setting_o),
  .first_current_output_o(first_current_output_o),
  .second_current_output_o(second_current_output_o));
